// ### logic/rbps_pkg.sv
package rbps_pkg;
	// gpio count
	localparam int GPIO_W = 28;
	localparam int PORT_W = 28;
	// pull enable delay after reset release: window 15..150 us
	localparam int CLK_MHZ = 25;
	localparam int PULL_DLY_MIN_US = 15;
	localparam int PULL_DLY_MAX_US = 150;
	localparam int PULL_DLY_CYC_MIN = PULL_DLY_MIN_US * CLK_MHZ;
	localparam int PULL_DLY_CYC_MAX = PULL_DLY_MAX_US * CLK_MHZ;
	// internal reset process length, inside the window
	localparam int IRST_CYC = PULL_DLY_CYC_MIN;
	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
	// register offsets
	localparam logic [7:0] REG_PLL_CFG = 8'h00;
	localparam logic [7:0] REG_BOOT_STAT = 8'h04;
	localparam logic [7:0] REG_SECURITY = 8'h08;
	localparam int SEC_OTP_BIT = 5;
	// pll field layout
	localparam int PLL_R_LSB = 0;
	localparam int PLL_R_W = 6;
	localparam int PLL_F_LSB = 8;
	localparam int PLL_F_W = 12;
	localparam int PLL_OD_LSB = 20;
	localparam int PLL_OD_W = 3;
	localparam logic [PLL_R_W-1:0] PLL_R_RST = 6'h00;
	localparam logic [PLL_F_W-1:0] PLL_F_RST = 12'h000;
	localparam logic [PLL_OD_W-1:0] PLL_OD_RST = 3'h0;
	// boot source codes
	localparam logic [1:0] BOOT_SRC_OTP = 2'h3;
	localparam logic [3:0] CLKBLK_RST = 4'h0;
	typedef enum logic [1:0] {RBPS_IN_RESET, RBPS_INTERNAL, RBPS_BOOT} rbps_state_e;
endpackage : rbps_pkg

// ### logic/rbps_top.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - hold reset state while the active-low chip reset input is low.
// - all gpio outputs disabled (high impedance) while reset is active.
// - after release run internal reset, then enable gpio pulls within 15-150 us.
// - boot starts at a clock speed chosen by the two boot-speed straps.
// - boot source normally comes from the two upper boot-source strap bits.
// - security bit 5 set forces boot from one-time-programmable memory.
// - pll divider and multiplier fields update on every pll register write.
// - every port attaches to clock block zero at reset.
module rbps_top import rbps_pkg::*; #(
	parameter logic [7:0] BOOT_SRC_MAP = 8'hE4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic rst_n_pin,
	input wire logic boot_speed_strap_lo,
	input wire logic boot_speed_strap_hi,
	input wire logic [1:0] boot_src_strap,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [GPIO_W-1:0] gpio_out_core,
	output logic [GPIO_W-1:0] gpio_oe_n,
	output logic [GPIO_W-1:0] gpio_pull_en,
	output logic [3:0] port_clk_blk,
	output logic core_reset,
	output logic boot_go,
	output logic [1:0] boot_speed,
	output logic [1:0] boot_src,
	output logic [PLL_R_W-1:0] pll_input_divider,
	output logic [PLL_F_W-1:0] pll_multiplier,
	output logic [PLL_OD_W-1:0] pll_output_divider
);

////////////////////////////////////////////////////////////////////////////////
	rbps_state_e state;
	rbps_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic pull_on;
	logic otp_force;
	logic [1:0] strap_src;
	logic [1:0] speed_q;
	logic [1:0] src_q;
	logic in_rst;
	logic done_cnt;
	logic [31:0] rd_mux;

	// pin reset treated as a synchronous level, kept separate from the asynchronous system reset
	assign in_rst = ~rst_n_pin;
	assign done_cnt = (cnt == CNT_ONE);

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			RBPS_IN_RESET: begin
				if (!in_rst) begin
					next_state = RBPS_INTERNAL;
					next_cnt = CNT_W'(IRST_CYC);
				end
			end
			RBPS_INTERNAL: begin
				next_cnt = cnt - CNT_ONE;
				if (done_cnt) begin
					next_state = RBPS_BOOT;
					next_cnt = CNT_ZERO;
				end
			end
			RBPS_BOOT: next_state = RBPS_BOOT;
			default: next_state = RBPS_IN_RESET;
		endcase
		if (in_rst) begin
			next_state = RBPS_IN_RESET;
			next_cnt = CNT_ZERO;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= RBPS_IN_RESET;
			cnt <= CNT_ZERO;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// straps caught on the release edge only; later changes on the pins are ignored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			speed_q <= 2'h0;
			src_q <= 2'h0;
		end else if (state == RBPS_IN_RESET && !in_rst) begin
			speed_q <= {boot_speed_strap_hi, boot_speed_strap_lo};
			src_q <= boot_src_strap;
		end
	end

	logic [7:0] sec_reg;
	logic [31:0] pll_reg;

	assign otp_force = sec_reg[SEC_OTP_BIT];
	assign strap_src = BOOT_SRC_MAP[{src_q, 1'b0} +: 2];
	assign pull_on = (state == RBPS_BOOT);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_speed <= 2'h0;
			boot_src <= 2'h0;
			boot_go <= 1'b0;
			core_reset <= 1'b1;
		end else begin
			boot_speed <= speed_q;
			boot_src <= otp_force ? BOOT_SRC_OTP : strap_src;
			boot_go <= pull_on;
			core_reset <= ~pull_on;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// registers; the pll and security registers both survive a pin reset for the host's sake
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pll_reg <= 32'h00000000;
			sec_reg <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == REG_PLL_CFG)
				pll_reg <= reg_wdata;
			if (reg_addr == REG_SECURITY)
				sec_reg <= reg_wdata[7:0];
		end
	end

	assign pll_input_divider = pll_reg[PLL_R_LSB +: PLL_R_W];
	assign pll_multiplier = pll_reg[PLL_F_LSB +: PLL_F_W];
	assign pll_output_divider = pll_reg[PLL_OD_LSB +: PLL_OD_W];

	assign rd_mux = (reg_addr == REG_PLL_CFG) ? {9'h000, pll_output_divider, pll_multiplier, 2'h0, pll_input_divider} :
		(reg_addr == REG_BOOT_STAT) ? {24'h000000, boot_go, pull_on, boot_src, 2'h0, boot_speed} :
		(reg_addr == REG_SECURITY) ? {24'h000000, sec_reg} : 32'h00000000;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
	end

////////////////////////////////////////////////////////////////////////////////
	logic drive_ok;
	assign drive_ok = pull_on;

	genvar gi;
	generate
		for (gi = 0; gi < GPIO_W; gi++) begin : g_gpio
			// high impedance until boot; core may drive afterwards
			assign gpio_oe_n[gi] = ~(drive_ok & gpio_out_core[gi]);
			assign gpio_pull_en[gi] = pull_on;
		end
	endgenerate

	assign port_clk_blk = CLKBLK_RST;

////////////////////////////////////////////////////////////////////////////////
	// cycles spent in the internal reset process, read only by the window check below
	logic [CNT_W-1:0] rel_cnt;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rel_cnt <= CNT_ZERO;
		else if (state == RBPS_IN_RESET)
			rel_cnt <= CNT_ZERO;
		else if (state == RBPS_INTERNAL)
			rel_cnt <= rel_cnt + CNT_ONE;
	end

	// reset hold and pad state
	a_reset_hiz: assert property (
		@(posedge clk) disable iff (rst) (state != RBPS_BOOT) |-> (&gpio_oe_n)
	) else $error("gpio driven during reset");
	a_reset_hold: assert property (
		@(posedge clk) disable iff (rst) in_rst |=> (state == RBPS_IN_RESET)
	) else $error("left reset while pin low");
	a_in_rst_cnt: assert property (
		@(posedge clk) disable iff (rst) in_rst |=> (cnt == CNT_ZERO)
	) else $error("counter runs in reset");
	a_core_rst_out: assert property (
		@(posedge clk) disable iff (rst) (state != RBPS_BOOT) |=> core_reset
	) else $error("core released before boot");
	a_boot_go_inv: assert property (
		@(posedge clk) disable iff (rst) boot_go == ~core_reset
	) else $error("boot go not inverse of core reset");
	a_hiz_pin: assert property (
		@(posedge clk) disable iff (rst) in_rst |=> (&gpio_oe_n)
	) else $error("gpio driven after pin reset");
	a_oe_follow: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_BOOT) |-> (gpio_oe_n == ~gpio_out_core)
	) else $error("gpio enable not following core");

	// internal reset process and pull enable window
	a_pull_delay: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_IN_RESET && !in_rst) ##1 (!in_rst)[*8] |-> !pull_on
	) else $error("pulls too early");
	a_pull_bound: assert property (
		@(posedge clk) disable iff (rst) $rose(state == RBPS_INTERNAL) |-> ##[1:400] (pull_on || in_rst)
	) else $error("pulls late");
	a_pull_window: assert property (
		@(posedge clk) disable iff (rst) $rose(pull_on) |->
			(rel_cnt >= CNT_W'(PULL_DLY_CYC_MIN) && rel_cnt <= CNT_W'(PULL_DLY_CYC_MAX))
	) else $error("pull enable outside window");
	a_cnt_load: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_IN_RESET && !in_rst) |=> (cnt == CNT_W'(IRST_CYC))
	) else $error("internal reset length wrong");
	a_cnt_down: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_INTERNAL && !done_cnt && !in_rst) |=> (cnt == $past(cnt) - CNT_ONE)
	) else $error("counter not counting down");
	a_boot_enter: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_INTERNAL && done_cnt && !in_rst) |=> (state == RBPS_BOOT)
	) else $error("boot not entered");
	a_no_early_boot: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_INTERNAL && !done_cnt) |=> (state != RBPS_BOOT)
	) else $error("boot entered early");
	a_pull_all: assert property (
		@(posedge clk) disable iff (rst) gpio_pull_en == {GPIO_W{pull_on}}
	) else $error("pull enables differ");
	a_no_pull_rst: assert property (
		@(posedge clk) disable iff (rst) in_rst |=> (gpio_pull_en == {GPIO_W{1'b0}})
	) else $error("pulls on in reset");

	// boot speed and source
	a_speed_out: assert property (
		@(posedge clk) disable iff (rst) 1'b1 |=> (boot_speed == $past(speed_q))
	) else $error("boot speed wrong");
	a_speed_in_boot: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_BOOT) |-> (boot_speed == speed_q)
	) else $error("boot speed not held in boot");
	a_boot_stay: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_BOOT && !in_rst) |=> (state == RBPS_BOOT)
	) else $error("boot state left");
	a_core_rel: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_BOOT) |=> !core_reset
	) else $error("core not released in boot");
	a_boot_go_rise: assert property (
		@(posedge clk) disable iff (rst) $rose(boot_go) |-> $past(pull_on)
	) else $error("boot go without boot state");
	a_stat_read: assert property (
		@(posedge clk) disable iff (rst) (reg_rd && reg_addr == REG_BOOT_STAT) |=> (reg_rdata[1:0] == $past(boot_speed))
	) else $error("status read speed wrong");
	a_strap_src: assert property (
		@(posedge clk) disable iff (rst) !otp_force |=> (boot_src == $past(strap_src))
	) else $error("boot source wrong");
	a_src_map: assert property (
		@(posedge clk) disable iff (rst)
			(!otp_force && !$past(otp_force) && state == RBPS_BOOT && $past(state) == RBPS_BOOT) |-> (boot_src == strap_src)
	) else $error("boot source not from straps");
	a_otp_force: assert property (
		@(posedge clk) disable iff (rst) otp_force |=> (boot_src == BOOT_SRC_OTP)
	) else $error("otp not forced");
	a_sec_write: assert property (
		@(posedge clk) disable iff (rst) (reg_wr && reg_addr == REG_SECURITY) |=> (sec_reg == $past(reg_wdata[7:0]))
	) else $error("security not written");
	a_sec_keep: assert property (
		@(posedge clk) disable iff (rst) !(reg_wr && reg_addr == REG_SECURITY) |=> $stable(sec_reg)
	) else $error("security changed without write");

	// strap capture
	a_speed_hold: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_BOOT && $past(state) == RBPS_BOOT) |-> $stable(speed_q)
	) else $error("strap resampled");
	a_strap_latch: assert property (
		@(posedge clk) disable iff (rst)
			(state == RBPS_IN_RESET && !in_rst) |=> (speed_q == $past({boot_speed_strap_hi, boot_speed_strap_lo}))
	) else $error("speed straps not caught");
	a_src_latch: assert property (
		@(posedge clk) disable iff (rst) (state == RBPS_IN_RESET && !in_rst) |=> (src_q == $past(boot_src_strap))
	) else $error("source straps not caught");
	a_src_hold: assert property (
		@(posedge clk) disable iff (rst) (state != RBPS_IN_RESET && $past(state) != RBPS_IN_RESET) |-> $stable(src_q)
	) else $error("source straps resampled");

	// pll configuration
	a_pll_write: assert property (
		@(posedge clk) disable iff (rst)
			(reg_wr && reg_addr == REG_PLL_CFG) |=> (pll_multiplier == $past(reg_wdata[PLL_F_LSB +: PLL_F_W]))
	) else $error("pll not updated");
	a_pll_in_write: assert property (
		@(posedge clk) disable iff (rst)
			(reg_wr && reg_addr == REG_PLL_CFG) |=> (pll_input_divider == $past(reg_wdata[PLL_R_LSB +: PLL_R_W]))
	) else $error("pll input divider not updated");
	a_pll_od_write: assert property (
		@(posedge clk) disable iff (rst)
			(reg_wr && reg_addr == REG_PLL_CFG) |=> (pll_output_divider == $past(reg_wdata[PLL_OD_LSB +: PLL_OD_W]))
	) else $error("pll output divider not updated");
	a_pll_keep: assert property (
		@(posedge clk) disable iff (rst) !(reg_wr && reg_addr == REG_PLL_CFG) |=> $stable(pll_reg)
	) else $error("pll changed without write");
	a_pll_read: assert property (
		@(posedge clk) disable iff (rst)
			(reg_rd && reg_addr == REG_PLL_CFG) |=> (reg_rdata[PLL_F_LSB +: PLL_F_W] == $past(pll_multiplier))
	) else $error("pll read wrong");

	// port clocking
	a_clk_blk: assert property (
		@(posedge clk) disable iff (rst) port_clk_blk == CLKBLK_RST
	) else $error("clock block not zero");
	a_clk_blk_rst: assert property (
		@(posedge clk) disable iff (rst) in_rst |-> (port_clk_blk == CLKBLK_RST)
	) else $error("clock block not zero in reset");

endmodule : rbps_top
`default_nettype wire

// ### dv/rbps_board.sv
`timescale 1ns/1ns
`default_nettype none
module rbps_board (
	input wire logic clk,
	input wire logic hold_req,
	input wire logic [3:0] strap_val,
	output logic rst_n_pin,
	output logic [3:0] straps
);
	initial begin
		rst_n_pin = 1'b0;
		straps = 4'h0;
	end
	// straps move only while the pin is held low, never around release
	always @(posedge clk) begin
		rst_n_pin <= !hold_req;
		if (hold_req && !rst_n_pin) begin
			straps <= strap_val;
		end
	end
endmodule : rbps_board
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import rbps_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hold_req = 1'b1;
	logic [3:0] strap_val = 4'h0;
	logic rst_n_pin, core_reset, boot_go, rd_d;
	logic [3:0] straps, port_clk_blk, s;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, pll_v;
	logic [GPIO_W-1:0] gpio_out_core = '0;
	logic [GPIO_W-1:0] gpio_oe_n, gpio_pull_en;
	logic [1:0] boot_speed, boot_src;
	logic [PLL_R_W-1:0] pll_in;
	logic [PLL_F_W-1:0] pll_mul;
	logic [PLL_OD_W-1:0] pll_od;
	logic [31:0] exp_q[$];
	int fail_count = 0;
	int comparisons = 0;
	int wait_cyc;
	always #20 clk = ~clk;
	rbps_board board_u (.clk(clk), .hold_req(hold_req), .strap_val(strap_val), .rst_n_pin(rst_n_pin), .straps(straps));
	rbps_top dut_u (.clk(clk), .rst(rst), .rst_n_pin(rst_n_pin), .boot_speed_strap_lo(straps[0]),
		.boot_speed_strap_hi(straps[1]), .boot_src_strap(straps[3:2]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_out_core(gpio_out_core), .gpio_oe_n(gpio_oe_n),
		.gpio_pull_en(gpio_pull_en), .port_clk_blk(port_clk_blk), .core_reset(core_reset), .boot_go(boot_go),
		.boot_speed(boot_speed), .boot_src(boot_src), .pll_input_divider(pll_in), .pll_multiplier(pll_mul),
		.pll_output_divider(pll_od));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// strobes are not dropped here so back-to-back calls never double-drive
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		if (r) begin
			exp_q.push_back(e);
		end
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask : bus
	task automatic boot(input logic [3:0] st, input logic [1:0] src);
		hold_req <= 1'b1;
		strap_val <= st;
		repeat (40) @(posedge clk);
		check({core_reset, 3'h0, gpio_pull_en}, {1'b1, 3'h0, 28'h0});
		check({28'h0, port_clk_blk}, {28'h0, CLKBLK_RST});
		check({4'h0, gpio_oe_n}, {4'h0, {GPIO_W{1'b1}}});
		hold_req <= 1'b0;
		wait_cyc = 0;
		while (rst_n_pin !== 1'b1) @(posedge clk);
		while (gpio_pull_en !== {GPIO_W{1'b1}} && wait_cyc < PULL_DLY_CYC_MAX + 10) begin
			@(posedge clk);
			wait_cyc++;
		end
		check(32'(wait_cyc >= PULL_DLY_CYC_MIN - 2 && wait_cyc <= PULL_DLY_CYC_MAX), 32'h1);
		repeat (2) @(posedge clk);
		check({core_reset, boot_go, boot_speed, boot_src}, {2'b01, st[1:0], src});
		check({4'h0, gpio_oe_n}, {4'h0, ~gpio_out_core});
		bus(1'b0, 1'b1, REG_BOOT_STAT, 32'h0, {24'h0, 2'b11, src, 2'h0, st[1:0]});
		bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
	endtask : boot
	task automatic summarize();
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1 && exp_q.size() > 0) begin
			check(reg_rdata, exp_q.pop_front());
		end
	end
	initial begin
		#(40 * 20000);
		fail_count++;
		summarize();
	end
	initial begin
		void'($urandom(29827));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		gpio_out_core <= GPIO_W'($urandom());
		s = 4'($urandom());
		boot(s, s[3:2]);
		for (int i = 0; i < 4; i++) begin
			// software keeps fields in range; vco limits are its own concern
			pll_v = {9'h0, 3'($urandom()), 12'($urandom()), 2'h0, 6'($urandom())};
			bus(1'b1, 1'b0, REG_PLL_CFG, pll_v, 32'h0);
			bus(1'b0, 1'b1, REG_PLL_CFG, 32'h0, pll_v);
			bus(1'b0, 1'b1, 8'h3C, 32'h0, 32'h0);
			bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
			check({9'h0, pll_od, pll_mul, 2'h0, pll_in}, pll_v);
		end
		bus(1'b1, 1'b0, REG_SECURITY, 32'h20, 32'h0);
		bus(1'b0, 1'b1, REG_SECURITY, 32'h0, 32'h20);
		bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
		s = 4'($urandom()) & 4'h7;
		boot(s, BOOT_SRC_OTP);
		bus(1'b1, 1'b0, REG_SECURITY, 32'h0, 32'h0);
		bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
		s = 4'($urandom());
		boot(s, s[3:2]);
		repeat (3) @(posedge clk);
		summarize();
	end
endmodule : testbench
`default_nettype wire
